// ### rtl/gpio_port.sv
`timescale 1ns/1ps
// Operation
// - Eight pins, each usable on its own as a digital input or output.
// - A direction bit of 1 turns the pin driver off so the pin is input.
// - A direction bit of 0 drives the pin from its output latch bit.
// - The latch is readable and reads give latch values, not pin levels.
// - After reset all direction bits are 1, so every pin is an input.
// - Pins 7 and 6 carry the fourth PWM pair, overriding latch data.
// - Complement remap set moves the third channel complement to pin 5.
// - Serial remap maps SPI out, SPI in/I2C data, clock to pins 1-3.
// - With fault remap set, the fault A input is taken from pin 4.
// - Remapped pin 0 with direction 1 feeds the Timer0 external clock.
// - Remapped pin 0 at direction 1 also feeds the Timer5 clock input.
// - SPI data out drives pin 1 instead of the latch when direction is 0.
// - Pin 2 feeds SPI data in at direction 1 and drives I2C data at 0.
// - No peripheral overrides the direction; alternate outputs drive only at direction 0.
module gpio_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dir_wr_en,
  input wire logic [7:0] dir_wr_data,
  input wire logic latch_wr_en,
  input wire logic [7:0] latch_wr_data,
  input wire logic port_wr_en,
  input wire logic [7:0] port_wr_data,
  input wire port_pkg::remap_cfg_t remap_cfg_in,
  input wire port_pkg::periph_drive_t periph_drive,
  input wire logic [7:0] pin_in,
  output logic [7:0] direction_reg,
  output logic [7:0] output_latch_reg,
  output logic [7:0] port_pins_reg,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output port_pkg::remap_cfg_t remap_active,
  output logic cfg_loaded,
  output port_pkg::periph_sense_t periph_sense
);

  port_pkg::port_state_t state_r;
  port_pkg::port_state_t state_nxt;

  logic [7:0] alt_en;
  logic [7:0] alt_val;
  logic [7:0] alt_od;
  logic [7:0] cell_out;
  logic [7:0] cell_oe;

  port_pkg::periph_drive_t drv;
  port_pkg::remap_cfg_t cfg;
  logic ser_here;

  assign drv = periph_drive;
  assign cfg = state_r.cfg;
  assign ser_here = cfg.serial_port_remap;

  // Serial functions decoded once so that drive and sense agree
  logic i2c_here;
  logic spi_here;
  logic tmr_here;

  assign i2c_here = ser_here && drv.i2c_en;
  assign spi_here = ser_here && drv.spi_en;
  // Timers ride on the serial remap bit; they have no bit of their own
  assign tmr_here = ser_here &&
                    (state_r.dir[port_pkg::PIN_TMR_CLK] == port_pkg::DIR_IN);

  // Which peripheral may own each pin, and with what value
  always_comb begin
    alt_en = port_pkg::ZERO_BYTE;
    alt_val = port_pkg::ZERO_BYTE;
    alt_od = port_pkg::ZERO_BYTE;

    // Pin 0 carries only inputs; nothing takes its driver

    // SPI data out replaces the latch on pin 1
    alt_en[port_pkg::PIN_SPI_DO] = spi_here;
    alt_val[port_pkg::PIN_SPI_DO] = drv.spi_data_out;

    // I2C data is open drain; in SPI mode pin 2 is input only
    alt_en[port_pkg::PIN_SPI_DI] = i2c_here;
    alt_val[port_pkg::PIN_SPI_DI] = drv.i2c_sda_out;
    alt_od[port_pkg::PIN_SPI_DI] = 1'b1;

    // Clock pin: SPI master clock, or open drain I2C clock
    if (drv.i2c_en) begin
      alt_en[port_pkg::PIN_SPI_CLK] = ser_here;
      alt_val[port_pkg::PIN_SPI_CLK] = drv.i2c_scl_out;
      alt_od[port_pkg::PIN_SPI_CLK] = 1'b1;
    end else begin
      // A slave SPI clock leaves the pin to the latch or to input
      alt_en[port_pkg::PIN_SPI_CLK] = spi_here &&
                                      drv.spi_clk_master;
      alt_val[port_pkg::PIN_SPI_CLK] = drv.spi_clk_out;
    end

    // Pin 4 is the fault input only; its driver stays with the latch

    // Third channel complement only when moved onto this port
    alt_en[port_pkg::PIN_CMP_OUT] = cfg.complement_out_remap &&
                                    drv.third_channel_en;
    alt_val[port_pkg::PIN_CMP_OUT] = drv.third_channel_complement_out;

    // Fourth channel pair always lives here
    alt_en[port_pkg::PIN_CH4_A] = drv.fourth_channel_en;
    alt_val[port_pkg::PIN_CH4_A] = drv.fourth_channel_out_a;
    alt_en[port_pkg::PIN_CH4_B] = drv.fourth_channel_en;
    alt_val[port_pkg::PIN_CH4_B] = drv.fourth_channel_out_b;
  end

  // One driver cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < port_pkg::PORT_W; gi++) begin : g_pin
      port_pin_cell u_cell (
        .dir_bit(state_r.dir[gi]),
        .latch_bit(state_r.latch[gi]),
        .alt_en(alt_en[gi]),
        .alt_val(alt_val[gi]),
        .alt_od(alt_od[gi]),
        .out_val(cell_out[gi]),
        .oe(cell_oe[gi])
      );
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;

    // Direction register write
    if (dir_wr_en) begin
      state_nxt.dir = dir_wr_data;
    end

    // Port data write lands in the latch; direct latch write wins a tie
    if (port_wr_en) begin
      state_nxt.latch = port_wr_data;
    end
    if (latch_wr_en) begin
      state_nxt.latch = latch_wr_data;
    end

    // Pins sampled every cycle for the port data read
    // Limitation: a read sees the pins one cycle late
    state_nxt.pins = pin_in;

    // Driver state registered so pins never see a combinational glitch
    state_nxt.pin_out = cell_out;
    state_nxt.pin_oe = cell_oe;

    // Remap taken once; later changes of the input are ignored
    if (!state_r.cfg_loaded) begin
      state_nxt.cfg = remap_cfg_in;
      state_nxt.cfg_loaded = 1'b1;
    end

    // Peripheral inputs from sampled pins, idle when mapped elsewhere
    state_nxt.sense = port_pkg::SENSE_RST;
    // Timer clocks listen only while pin 0 is an input
    if (tmr_here) begin
      state_nxt.sense.timer0_ext_clock_in =
        state_r.pins[port_pkg::PIN_TMR_CLK];
      state_nxt.sense.timer5_ext_clock_in =
        state_r.pins[port_pkg::PIN_TMR_CLK];
    end
    // Serial inputs stay idle unless the serial remap is set
    if (ser_here) begin
      // Data pin read in either direction so open drain I2C sees the bus
      if (drv.i2c_en) begin
        state_nxt.sense.i2c_sda_in =
          state_r.pins[port_pkg::PIN_SPI_DI];
        state_nxt.sense.i2c_scl_in =
          state_r.pins[port_pkg::PIN_SPI_CLK];
      end else begin
        if (state_r.dir[port_pkg::PIN_SPI_DI] == port_pkg::DIR_IN) begin
          state_nxt.sense.spi_data_in =
            state_r.pins[port_pkg::PIN_SPI_DI];
        end
        if (state_r.dir[port_pkg::PIN_SPI_CLK] == port_pkg::DIR_IN) begin
          state_nxt.sense.spi_clk_in =
            state_r.pins[port_pkg::PIN_SPI_CLK];
        end
      end
    end
    // Fault pin ignores direction; an output pin can trip it too
    if (cfg.fault_a_remap) begin
      state_nxt.sense.fault_a_input =
        state_r.pins[port_pkg::PIN_FAULT_A];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r.dir <= port_pkg::DIR_RST;
      state_r.latch <= port_pkg::LATCH_RST;
      state_r.pins <= port_pkg::ZERO_BYTE;
      // Drivers start released so the pins float to the board
      state_r.pin_out <= port_pkg::LATCH_RST;
      state_r.pin_oe <= port_pkg::ZERO_BYTE;
      // Remap forgotten so each release captures it afresh
      state_r.cfg <= port_pkg::REMAP_RST;
      state_r.cfg_loaded <= 1'b0;
      state_r.sense <= port_pkg::SENSE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Every output is a register field, never a decode
  // Latch read returns stored value for safe read-modify-write
  assign output_latch_reg = state_r.latch;
  assign direction_reg = state_r.dir;
  assign port_pins_reg = state_r.pins;
  assign pin_out = state_r.pin_out;
  assign pin_oe = state_r.pin_oe;
  assign remap_active = state_r.cfg;
  assign cfg_loaded = state_r.cfg_loaded;
  assign periph_sense = state_r.sense;

endmodule

// ### include/port_pkg.sv
package port_pkg;

  // Geometry of the port
  localparam int unsigned PORT_W = 8;

  // Reset values: every pin an input, latch cleared
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Direction bit encodings
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN = 1'b1;

  // Pin positions of the alternate functions
  localparam int unsigned PIN_TMR_CLK = 0;
  localparam int unsigned PIN_SPI_DO = 1;
  localparam int unsigned PIN_SPI_DI = 2;
  localparam int unsigned PIN_SPI_CLK = 3;
  localparam int unsigned PIN_FAULT_A = 4;
  localparam int unsigned PIN_CMP_OUT = 5;
  localparam int unsigned PIN_CH4_A = 6;
  localparam int unsigned PIN_CH4_B = 7;

  // Levels handed to peripherals when a function sits on the other port
  localparam logic TMR_CLK_IDLE = 1'b0;
  localparam logic FAULT_IDLE = 1'b1;
  localparam logic SPI_IDLE = 1'b0;
  localparam logic I2C_IDLE = 1'b1;

  typedef struct packed {
    logic complement_out_remap;
    logic serial_port_remap;
    logic fault_a_remap;
  } remap_cfg_t;

  localparam remap_cfg_t REMAP_RST = '0;

  // Outputs of peripherals that may take over pins
  typedef struct packed {
    logic third_channel_en;
    logic third_channel_complement_out;
    logic fourth_channel_en;
    logic fourth_channel_out_a;
    logic fourth_channel_out_b;
    logic spi_en;
    logic spi_data_out;
    logic spi_clk_master;
    logic spi_clk_out;
    logic i2c_en;
    logic i2c_sda_out;
    logic i2c_scl_out;
  } periph_drive_t;

  // Pin levels handed to peripherals
  typedef struct packed {
    logic timer0_ext_clock_in;
    logic timer5_ext_clock_in;
    logic fault_a_input;
    logic spi_data_in;
    logic spi_clk_in;
    logic i2c_sda_in;
    logic i2c_scl_in;
  } periph_sense_t;

  localparam periph_sense_t SENSE_RST = '{
    timer0_ext_clock_in: TMR_CLK_IDLE,
    timer5_ext_clock_in: TMR_CLK_IDLE,
    fault_a_input: FAULT_IDLE,
    spi_data_in: SPI_IDLE,
    spi_clk_in: SPI_IDLE,
    i2c_sda_in: I2C_IDLE,
    i2c_scl_in: I2C_IDLE
  };

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] pins;
    logic [PORT_W-1:0] pin_out;
    logic [PORT_W-1:0] pin_oe;
    remap_cfg_t cfg;
    logic cfg_loaded;
    periph_sense_t sense;
  } port_state_t;

endpackage

// ### rtl/port_pin_cell.sv
`timescale 1ns/1ps
module port_pin_cell (
  input wire logic dir_bit,
  input wire logic latch_bit,
  input wire logic alt_en,
  input wire logic alt_val,
  input wire logic alt_od,
  output logic out_val,
  output logic oe
);

  always_comb begin
    out_val = latch_bit;
    oe = (dir_bit == port_pkg::DIR_OUT);
    if (alt_en && (dir_bit == port_pkg::DIR_OUT)) begin
      if (alt_od) begin
        // Open drain: peripheral owns the enable
        out_val = 1'b0;
        oe = ~alt_val;
      end else begin
        out_val = alt_val;
        oe = 1'b1;
      end
    end
  end

endmodule

// ### test/gpio_port_properties.sv
`timescale 1ns/1ps
module gpio_port_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dir_wr_en,
  input wire logic [7:0] dir_wr_data,
  input wire logic latch_wr_en,
  input wire logic [7:0] latch_wr_data,
  input wire port_pkg::periph_drive_t periph_drive,
  input wire logic [7:0] direction_reg,
  input wire logic [7:0] output_latch_reg,
  input wire logic [7:0] port_pins_reg,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire port_pkg::remap_cfg_t remap_active,
  input wire logic cfg_loaded,
  input wire port_pkg::periph_sense_t periph_sense
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_spi_claim;
    remap_active.serial_port_remap && periph_drive.spi_en && !direction_reg[1];
  endsequence
  sequence s_timer_claim;
    remap_active.serial_port_remap && direction_reg[0];
  endsequence
  a_dir_write: assert property (
    dir_wr_en |=> direction_reg == $past(dir_wr_data))
    else $error("direction write lost");
  a_latch_write: assert property (
    latch_wr_en |=> output_latch_reg == $past(latch_wr_data))
    else $error("latch write lost");
  a_input_hiz: assert property (
    1'b1 |=> (pin_oe & $past(direction_reg)) == 8'h00)
    else $error("input pin driven");
  a_pwm_pair: assert property (
    periph_drive.fourth_channel_en && direction_reg[7:6] == 2'h0 |=>
    pin_out[7] == $past(periph_drive.fourth_channel_out_b) &&
    pin_out[6] == $past(periph_drive.fourth_channel_out_a))
    else $error("pwm pair not on pins");
  a_spi_out: assert property (
    s_spi_claim |=> pin_out[1] == $past(periph_drive.spi_data_out))
    else $error("spi out not on pin");
  a_fault_sense: assert property (
    remap_active.fault_a_remap |=>
    periph_sense.fault_a_input == $past(port_pins_reg[4]))
    else $error("fault input wrong");
  a_timer_sense: assert property (
    s_timer_claim |=> periph_sense.timer0_ext_clock_in ==
    $past(port_pins_reg[0]) && periph_sense.timer5_ext_clock_in ==
    $past(port_pins_reg[0]))
    else $error("timer clock input wrong");
  a_cfg_static: assert property (
    cfg_loaded |=> $stable(remap_active))
    else $error("remap changed");
endmodule
bind gpio_port gpio_port_properties gpio_port_properties_inst (.ref_clk,
  .rst, .dir_wr_en, .dir_wr_data, .latch_wr_en, .latch_wr_data,
  .periph_drive, .direction_reg, .output_latch_reg, .port_pins_reg,
  .pin_out, .pin_oe, .remap_active, .cfg_loaded, .periph_sense);

// ### test/pin_world.sv
`timescale 1ns/1ps
module pin_world (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_oe,
  output logic [7:0] pin_in
);
  // Pull-ups everywhere; a drive clash reads low, like wired-and
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = (!pin_oe[i] || pin_out[i]) && (!ext_oe[i] || ext_val[i]);
    end
  end
endmodule

// ### test/gpio_port_tb.sv
`timescale 1ns/1ps
module gpio_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] wr_en = 3'h0;
  logic [7:0] wr_data = 8'h00;
  port_pkg::remap_cfg_t remap = 3'h7;
  port_pkg::periph_drive_t pd = '0;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_oe = 8'h00;
  logic [7:0] pin_in, direction_reg, output_latch_reg, port_pins_reg;
  logic [7:0] pin_out, pin_oe;
  port_pkg::remap_cfg_t remap_active;
  logic cfg_loaded;
  port_pkg::periph_sense_t periph_sense;
  int n_fail = 0;
  int check_count = 0;
  gpio_port gpio_port_inst (.ref_clk, .rst, .dir_wr_en(wr_en[2]),
    .dir_wr_data(wr_data), .latch_wr_en(wr_en[1]), .latch_wr_data(wr_data),
    .port_wr_en(wr_en[0]), .port_wr_data(wr_data), .remap_cfg_in(remap),
    .periph_drive(pd), .pin_in, .direction_reg, .output_latch_reg,
    .port_pins_reg, .pin_out, .pin_oe, .remap_active, .cfg_loaded,
    .periph_sense);
  pin_world pin_world_inst (.pin_out, .pin_oe, .ext_val, .ext_oe, .pin_in);
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One bus feeds all three write ports, so enables pick the target
  task automatic wr(input logic [2:0] en, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= en;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 3'h0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset;
    step(4);
    chk("dir at reset", direction_reg, 8'hFF);
    chk("oe at reset", pin_oe, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    step(2);
    chk("remap", {4'h0, cfg_loaded, remap_active}, 8'h0F);
    // Later changes of the remap input must not reach the port
    @(posedge ref_clk);
    remap <= 3'h0;
    step(2);
    chk("remap held", {4'h0, cfg_loaded, remap_active}, 8'h0F);
    $display("test reset done");
  endtask
  task automatic t_gpio;
    wr(3'h4, 8'hCF);
    wr(3'h2, 8'hA5);
    step(1);
    chk("oe", pin_oe, 8'h30);
    chk("out", pin_out, 8'hA5);
    wr(3'h1, 8'h5A);
    ext_oe <= 8'hCF;
    ext_val <= 8'h81;
    step(3);
    chk("latch", output_latch_reg, 8'h5A);
    chk("pins", port_pins_reg,
        (8'h81 & 8'hCF) | (8'h5A & 8'h30));
    $display("test gpio done");
  endtask
  task automatic t_alt;
    wr(3'h6, 8'h00);
    pd <= 12'hF60;
    ext_oe <= 8'h00;
    step(2);
    chk("alt out", pin_out, 8'h62);
    chk("cmp pin", {7'h00, pin_out[5]}, 8'h01);
    chk("spi pin", {7'h00, pin_out[1]}, 8'h01);
    @(posedge ref_clk);
    pd <= 12'hF65;
    step(2);
    chk("i2c oe", pin_oe, 8'hF7);
    wr(3'h4, 8'h11);
    ext_oe <= 8'h11;
    ext_val <= 8'h01;
    step(3);
    chk("sense", {1'b0, periph_sense}, 8'h61);
    $display("test alt done");
  endtask
  // Mid-run reset: remap taken afresh, unmapped functions fall back
  task automatic t_rearm;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    step(1);
    chk("rearm dir", direction_reg, 8'hFF);
    chk("rearm remap", {4'h0, cfg_loaded, remap_active}, 8'h08);
    wr(3'h4, 8'h00);
    step(2);
    chk("unmapped out", pin_out, 8'h40);
    chk("unmapped oe", pin_oe, 8'hFF);
    chk("idle sense", {1'b0, periph_sense}, 8'h13);
    $display("test rearm done");
  endtask
  // Backstop against a stuck sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    finish_test;
  end
  initial begin
    t_reset;
    t_gpio;
    t_alt;
    t_rearm;
    finish_test;
  end
endmodule
